// [src/nvsc_host.sv]
// host controller for the nonvolatile sram: pin drive and command sequencing
//
// Functional notes
// - commands issued only as ordinary ce-timed reads.
// - six reads to command addresses, in order, nothing between.
// - write enable held high over all six command reads.
// - each command read lasts at least 35 ns, address held steady.
// - sixth read data discarded.
// - no access until recall done; recall waits 200 us.
// - hardware store pulse on hw_store_busy_n low at least 15 ns.
// - hw_store_busy_n released (not driven) by us during reads and writes.
`timescale 1ns/1ps
module nvsc_host #(
    parameter int unsigned    SOFT_CMD_CYCLES = nvsc_pkg::SOFT_CMD_CYC,
    parameter int unsigned    RECALL_CYCLES   = nvsc_pkg::RECALL_CYC,
    parameter int unsigned    STORE_CYCLES    = nvsc_pkg::STORE_CYC,
    parameter logic [89:0]    STORE_SEQ       = {15'h0001, 15'h0002,
                                                 15'h0003, 15'h0004,
                                                 15'h0005, 15'h0006},
    parameter logic [89:0]    RECALL_SEQ      = {15'h0011, 15'h0012,
                                                 15'h0013, 15'h0014,
                                                 15'h0015, 15'h0016}
) (
    // clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    // user request side
    input  wire logic                i_req_valid,
    input  wire nvsc_pkg::nvsc_req_t i_req,
    output logic                     o_req_ready,
    output logic                     o_rd_valid,
    output logic [7:0]               o_rd_data,
    output logic                     o_nv_done,
    // device pins
    output nvsc_pkg::nvsc_pins_t     o_pins,
    input  wire logic [7:0]          i_dq,
    output logic [7:0]               o_dq,
    output logic                     o_dq_oe,
    input  wire logic                i_hw_store_busy_n,
    output logic                     o_hw_store_busy_n,
    output logic                     o_hw_store_busy_oe
);
    typedef enum logic [2:0] {
        NVSC_IDLE  = 3'h0,
        NVSC_READ  = 3'h1,
        NVSC_WRITE = 3'h2,
        NVSC_SEQ   = 3'h3,
        NVSC_GAP   = 3'h4,
        NVSC_HWPL  = 3'h5,
        NVSC_WAIT  = 3'h6
    } nvsc_state_t;
    nvsc_state_t          state_q, state_d;
    logic [31:0]          cnt_q;
    logic [2:0]           idx_q;
    logic                 recall_q;
    nvsc_pkg::nvsc_op_t   op_q;
    logic [14:0]          seq_addr;
    logic [2:0]           sync_q;
    logic                 busy_n_q;
    logic                 hw_q;
    // three flops; second and third must agree before a change counts
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync_q   <= 3'h7;
            busy_n_q <= 1'b1;
        end else if (i_ce) begin
            sync_q <= {sync_q[1:0], i_hw_store_busy_n};
            if (sync_q[1] == sync_q[2]) begin
                busy_n_q <= sync_q[2];
            end
        end
    end

    wire cnt_done   = (cnt_q == 32'h0);
    wire take       = (state_q == NVSC_IDLE) && i_req_valid && busy_n_q;
    wire is_hwstore = (i_req.op == nvsc_pkg::NVSC_OP_STORE) && hw_q;
    wire last_seq   = (idx_q == 3'(nvsc_pkg::NUM_SEQ - 1));
    // wait count after the command: recall or store time
    wire [31:0] wait_cyc = recall_q ? 32'(RECALL_CYCLES)
                                    : 32'(STORE_CYCLES);
    wire [2:0] idx_nxt    = take ? 3'h0 : (state_q == NVSC_SEQ && cnt_done)
                                        ? idx_q + 3'h1 : idx_q;
    wire       recall_nxt = take ? (i_req.op == nvsc_pkg::NVSC_OP_RECALL)
                                 : recall_q;
    // lookup one step ahead: the table output is registered
    nvsc_seq_rom #(
        .STORE_SEQ  (STORE_SEQ),
        .RECALL_SEQ (RECALL_SEQ)
    ) u_rom (
        .i_clock  (i_clock),
        .i_ce     (i_ce),
        .i_recall (recall_nxt),
        .i_index  (idx_nxt),
        .o_addr   (seq_addr)
    );

    // hardware store is used when the request carries all-ones address
    always_comb hw_q = (i_req.addr == 15'h7fff);

    always_comb begin
        state_d = state_q;
        case (state_q)
            NVSC_IDLE: begin
                if (take) begin
                    case (i_req.op)
                        nvsc_pkg::NVSC_OP_READ:  state_d = NVSC_READ;
                        nvsc_pkg::NVSC_OP_WRITE: state_d = NVSC_WRITE;
                        default: state_d = is_hwstore ? NVSC_HWPL : NVSC_GAP;
                    endcase
                end
            end
            NVSC_READ, NVSC_WRITE: begin
                if (cnt_done) state_d = NVSC_IDLE;
            end
            NVSC_GAP:  state_d = NVSC_SEQ;
            NVSC_SEQ: begin
                if (cnt_done) state_d = last_seq ? NVSC_WAIT : NVSC_GAP;
            end
            NVSC_HWPL: begin
                if (cnt_done) state_d = NVSC_WAIT;
            end
            NVSC_WAIT: begin
                // early end only for a pin store (index still zero)
                if (cnt_done || (op_q == nvsc_pkg::NVSC_OP_STORE &&
                                 idx_q == 3'h0 && busy_n_q &&
                                 cnt_q < 32'(STORE_CYCLES) -
                                 32'(nvsc_pkg::BUSY_RELEASE_CYC)))
                    state_d = NVSC_IDLE;
            end
            default: state_d = NVSC_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q            <= NVSC_IDLE;
            cnt_q              <= 32'h0;
            idx_q              <= 3'h0;
            recall_q           <= 1'b0;
            op_q               <= nvsc_pkg::NVSC_OP_READ;
            o_pins             <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                    addr: 15'h0};
            o_dq               <= 8'h0;
            o_dq_oe            <= 1'b0;
            o_hw_store_busy_n  <= 1'b1;
            o_hw_store_busy_oe <= 1'b0;
            o_req_ready        <= 1'b0;
            o_rd_valid         <= 1'b0;
            o_rd_data          <= 8'h0;
            o_nv_done          <= 1'b0;
        end else if (i_ce) begin
            state_q     <= state_d;
            o_rd_valid  <= 1'b0;
            o_nv_done   <= 1'b0;
            o_req_ready <= (state_d == NVSC_IDLE) && busy_n_q;
            if (!cnt_done) cnt_q <= cnt_q - 32'h1;
            case (state_q)
                NVSC_IDLE: if (take) begin
                    op_q     <= i_req.op;
                    recall_q <= (i_req.op == nvsc_pkg::NVSC_OP_RECALL);
                    idx_q    <= 3'h0;
                    if (i_req.op == nvsc_pkg::NVSC_OP_READ) begin
                        o_pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0,
                                    addr: i_req.addr};
                        cnt_q  <= 32'(nvsc_pkg::READ_CYCLE_CYC - 1);
                    end else if (i_req.op == nvsc_pkg::NVSC_OP_WRITE) begin
                        o_pins  <= '{ce_n: 1'b0, we_n: 1'b0, oe_n: 1'b1,
                                     addr: i_req.addr};
                        o_dq    <= i_req.wdata;
                        o_dq_oe <= 1'b1;
                        cnt_q   <= 32'(nvsc_pkg::WRITE_PULSE_CYC - 1);
                    end else if (is_hwstore) begin
                        o_hw_store_busy_n  <= 1'b0;
                        o_hw_store_busy_oe <= 1'b1;
                        cnt_q <= 32'(nvsc_pkg::HW_STORE_PULSE_CYC - 1);
                    end
                end
                NVSC_READ: if (cnt_done) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data  <= i_dq;
                    o_pins     <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                    addr: o_pins.addr};
                end
                NVSC_WRITE: if (cnt_done) begin
                    o_pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                 addr: o_pins.addr};
                    o_dq_oe <= 1'b0;
                end
                NVSC_GAP: begin
                    // ce-timed read, we high, address steady
                    o_pins <= '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0,
                                addr: seq_addr};
                    cnt_q  <= 32'(nvsc_pkg::READ_CYCLE_CYC - 1);
                end
                NVSC_SEQ: if (cnt_done) begin
                    // sixth byte is not passed on; next address
                    o_pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                addr: o_pins.addr};
                    idx_q  <= idx_q + 3'h1;
                    // hold off for latency plus operation
                    if (last_seq) cnt_q <= 32'(SOFT_CMD_CYCLES) + wait_cyc;
                end
                NVSC_HWPL: if (cnt_done) begin
                    o_hw_store_busy_n  <= 1'b1;
                    o_hw_store_busy_oe <= 1'b0;
                    cnt_q <= 32'(STORE_CYCLES);
                end
                NVSC_WAIT: begin
                    if (state_d == NVSC_IDLE) o_nv_done <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // command read holds ce low for the full count
    property p_seq_read_len;
        @(posedge i_clock) disable iff (i_rst || !i_ce)
        $fell(o_pins.ce_n) && state_q == NVSC_SEQ |->
            !o_pins.ce_n [*7];
    endproperty
    a_seq_read_len: assert property (p_seq_read_len)
        else $error("command read too short");

    property p_we_high;
        @(posedge i_clock) disable iff (i_rst)
        state_q == NVSC_SEQ |-> o_pins.we_n;
    endproperty
    a_we_high: assert property (p_we_high)
        else $error("we low during command read");

    // busy pin released during ordinary access
    property p_busy_high;
        @(posedge i_clock) disable iff (i_rst)
        (state_q == NVSC_READ || state_q == NVSC_WRITE) |->
            o_hw_store_busy_n && !o_hw_store_busy_oe;
    endproperty
    a_busy_high: assert property (p_busy_high)
        else $error("busy pin driven during access");

    // pulse lasts at least three cycles
    property p_hw_pulse;
        @(posedge i_clock) disable iff (i_rst || !i_ce)
        $fell(o_hw_store_busy_n) |-> !o_hw_store_busy_n [*3];
    endproperty
    a_hw_pulse: assert property (p_hw_pulse)
        else $error("store pulse too short");

    property p_no_seq_data;
        @(posedge i_clock) disable iff (i_rst)
        state_q == NVSC_SEQ |=> !o_rd_valid;
    endproperty
    a_no_seq_data: assert property (p_no_seq_data)
        else $error("command byte returned");

    property p_locked;
        @(posedge i_clock) disable iff (i_rst)
        state_q == NVSC_WAIT |-> o_pins.ce_n;
    endproperty
    a_locked: assert property (p_locked)
        else $error("access during nonvolatile cycle");

    // read mode: oe low, we high
    property p_read_mode;
        @(posedge i_clock) disable iff (i_rst)
        state_q == NVSC_READ |-> !o_pins.oe_n && o_pins.we_n && !o_dq_oe;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("bad read pin mode");

    // index advances by one per read
    property p_order;
        @(posedge i_clock) disable iff (i_rst || !i_ce)
        state_q == NVSC_SEQ && cnt_done && !last_seq |=>
            idx_q == $past(idx_q) + 3'h1;
    endproperty
    a_order: assert property (p_order)
        else $error("sequence order broken");

    c_read:   cover property (@(posedge i_clock) o_rd_valid);
    c_nvdone: cover property (@(posedge i_clock) o_nv_done && recall_q);
    c_hw:     cover property (@(posedge i_clock) $fell(o_hw_store_busy_n));
endmodule : nvsc_host

// [src/nvsc_pkg.sv]
// package: constants and carrier types for the nv sram host controller
package nvsc_pkg;
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam int unsigned ADDR_W            = 15;
    localparam int unsigned DATA_W            = 8;
    // read cycle least time, ns
    localparam int unsigned READ_CYCLE_NS     = 35;
    localparam int unsigned READ_CYCLE_CYC    =
        (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // write pulse least time, ns
    localparam int unsigned WRITE_PULSE_NS    = 35;
    localparam int unsigned WRITE_PULSE_CYC   =
        (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // hw_store_pulse_min, ns
    localparam int unsigned HW_STORE_PULSE_NS = 15;
    localparam int unsigned HW_STORE_PULSE_CYC =
        (HW_STORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // busy_release_time and write_grace_time, ns
    localparam int unsigned BUSY_RELEASE_NS   = 25;
    localparam int unsigned BUSY_RELEASE_CYC  =
        (BUSY_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // soft_cmd_latency, us
    localparam int unsigned SOFT_CMD_US       = 100;
    localparam int unsigned SOFT_CMD_CYC      =
        SOFT_CMD_US * 1000000 / CLK_PERIOD_PS;
    // recall_time, us
    localparam int unsigned RECALL_US         = 200;
    localparam int unsigned RECALL_CYC        =
        RECALL_US * 1000000 / CLK_PERIOD_PS;
    // store cycle, ms
    localparam int unsigned STORE_MS          = 8;
    // scaled before the product so 32 bits do not overflow
    localparam int unsigned STORE_CYC         =
        STORE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int unsigned NUM_SEQ           = 6;

    typedef enum logic [1:0] {
        NVSC_OP_READ   = 2'h0,
        NVSC_OP_WRITE  = 2'h1,
        NVSC_OP_STORE  = 2'h2,
        NVSC_OP_RECALL = 2'h3
    } nvsc_op_t;

    // user request carrier
    typedef struct packed {
        nvsc_op_t              op;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } nvsc_req_t;

    // device pin drive carrier
    typedef struct packed {
        logic                  ce_n;
        logic                  we_n;
        logic                  oe_n;
        logic [ADDR_W-1:0]     addr;
    } nvsc_pins_t;
endpackage : nvsc_pkg

// [src/nvsc_seq_rom.sv]
// small table of the six command addresses for store and recall
`timescale 1ns/1ps
module nvsc_seq_rom #(
    parameter logic [6*15-1:0] STORE_SEQ  = {15'h0001, 15'h0002, 15'h0003,
                                             15'h0004, 15'h0005, 15'h0006},
    parameter logic [6*15-1:0] RECALL_SEQ = {15'h0011, 15'h0012, 15'h0013,
                                             15'h0014, 15'h0015, 15'h0016}
) (
    // clock
    input  wire logic        i_clock,
    input  wire logic        i_ce,
    // lookup
    input  wire logic        i_recall,
    input  wire logic [2:0]  i_index,
    // registered data
    output logic      [14:0] o_addr
);
    logic [14:0] store_w;
    logic [14:0] recall_w;
    // entry 0 sits in the top slice
    assign store_w  = STORE_SEQ[(5 - int'(i_index)) * 15 +: 15];
    assign recall_w = RECALL_SEQ[(5 - int'(i_index)) * 15 +: 15];

    always_ff @(posedge i_clock) begin
        if (i_ce) begin
            o_addr <= i_recall ? recall_w : store_w;
        end
    end
endmodule : nvsc_seq_rom

// [test/nvsc_dev_model.sv]
// behavioural nonvolatile sram seen from its pins
`timescale 1ns/1ps
module nvsc_dev_model #(
    parameter int unsigned LAT_CYC    = 10,
    parameter int unsigned STORE_T    = 50,
    parameter int unsigned RECALL_T   = 30,
    parameter logic [89:0] STORE_SEQ  = {15'h0001, 15'h0002, 15'h0003,
                                         15'h0004, 15'h0005, 15'h0006},
    parameter logic [89:0] RECALL_SEQ = {15'h0011, 15'h0012, 15'h0013,
                                         15'h0014, 15'h0015, 15'h0016}
) (
    // host side pins
    input  wire logic                 i_clock,
    input  wire nvsc_pkg::nvsc_pins_t i_pins,
    input  wire logic [7:0]           i_dq,
    input  wire logic                 i_dq_oe,
    input  wire logic                 i_busy_n,
    // device drive and protocol faults seen
    output logic [7:0]                o_dq,
    output logic                      o_busy_low = 1'b0,
    output logic [7:0]                o_viol     = 8'h00
);
    logic [7:0]  sram [0:32767];
    logic [7:0]  nvm  [0:32767];
    logic        latch_q = 1'b0;
    logic        inhib_q = 1'b0;
    logic [7:0]  last_q  = 8'h00;
    logic        ce_p    = 1'b1;
    logic        bad     = 1'b0;
    logic [14:0] adr     = 15'h0000;
    logic        rd_on;
    int          si = 0, ri = 0, len = 0, wt = 0, ph = 0, kind = 0, low = 0;

    function automatic logic [14:0] pick(input logic [89:0] s, input int i);
        return s[(5-i)*15 +: 15];
    endfunction : pick

    // read drive; released bus shows inverse of last byte
    assign rd_on = !i_pins.ce_n && i_pins.we_n && !i_pins.oe_n && !inhib_q;
    assign o_dq  = rd_on ? sram[i_pins.addr] : ~last_q;

    always @(posedge i_clock) begin
        if (rd_on) last_q <= sram[i_pins.addr];
        // writes outside lockout set the latch
        if (!i_pins.ce_n && !i_pins.we_n && i_dq_oe && !inhib_q) begin
            sram[i_pins.addr] = i_dq;
            latch_q = 1'b1;
        end
        // busy low during an access is a host fault
        if (!i_pins.ce_n && !i_busy_n) o_viol++;
        // ce-timed read of 7+ cycles, we high, addr held
        if (!i_pins.ce_n) begin
            if (ce_p) begin
                len = 0;
                bad = 1'b0;
                adr = i_pins.addr;
            end
            len++;
            bad = bad | !i_pins.we_n | (i_pins.addr != adr);
        end else if (!ce_p) begin
            // six reads in table order, else restart
            bad = bad | (len < 7);
            si = (!bad && adr == pick(STORE_SEQ, si)) ? si + 1 :
                 (!bad && adr == pick(STORE_SEQ, 0)) ? 1 : 0;
            ri = (!bad && adr == pick(RECALL_SEQ, ri)) ? ri + 1 :
                 (!bad && adr == pick(RECALL_SEQ, 0)) ? 1 : 0;
            if (ph == 0 && (si == 6 || ri == 6)) begin
                kind = (si == 6) ? 1 : 2;
                ph = 1;
                wt = LAT_CYC;
                si = 0;
                ri = 0;
                // outputs off, io blocked from now
                inhib_q <= 1'b1;
            end
        end
        ce_p = i_pins.ce_n;
        // pulse of 3+ cycles; unwritten store never pulls busy
        if (!i_busy_n && !o_busy_low) begin
            low++;
        end else begin
            if (low > 0 && low < 3) o_viol++;
            low = 0;
        end
        if (low == 3 && ph == 0 && latch_q) begin
            ph = 3;
            wt = 5;
            kind = 1;
            o_busy_low <= 1'b1;
        end
        // latency or grace, then timed op under lockout
        if (ph != 0 && wt > 0) begin
            wt--;
        end else if (ph == 1 || ph == 3) begin
            ph = 2;
            inhib_q <= 1'b1;
            wt = (kind == 1) ? STORE_T : RECALL_T;
        end else if (ph == 2) begin
            for (int k = 0; k < 32768; k++) begin
                if (kind == 1) nvm[k] = sram[k];
                else sram[k] = nvm[k];
            end
            if (kind == 1) latch_q = 1'b0;
            ph = 0;
            inhib_q <= 1'b0;
            o_busy_low <= 1'b0;
        end
    end
endmodule : nvsc_dev_model

// [test/nvsc_host_tb_top.sv]
// self-checking bench for the nv sram host controller
`timescale 1ns/1ps
module nvsc_host_tb_top;
    localparam nvsc_pkg::nvsc_op_t RD = nvsc_pkg::NVSC_OP_READ;
    localparam nvsc_pkg::nvsc_op_t WR = nvsc_pkg::NVSC_OP_WRITE;
    localparam nvsc_pkg::nvsc_op_t ST = nvsc_pkg::NVSC_OP_STORE;
    localparam nvsc_pkg::nvsc_op_t RC = nvsc_pkg::NVSC_OP_RECALL;

    logic                 i_clock     = 1'b0;
    logic                 i_rst       = 1'b1;
    logic                 i_ce        = 1'b1;
    logic                 i_req_valid = 1'b0;
    nvsc_pkg::nvsc_req_t  i_req       = '0;
    nvsc_pkg::nvsc_pins_t o_pins;
    logic                 o_req_ready, o_rd_valid, o_nv_done, o_dq_oe;
    logic                 bsy_o, bsy_oe, dev_low, bsy_wire;
    logic [7:0]           o_rd_data, o_dq, dev_dq, dq_bus, viol, rd;
    int                   err_total    = 0;
    int                   total_checks = 0;
    int                   n_rdv        = 0;
    int                   cyc;

    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_rd_valid === 1'b1) n_rdv++;
    assign dq_bus   = o_dq_oe ? o_dq : dev_dq;
    // open drain busy line with pull-up
    assign bsy_wire = ~((bsy_oe & ~bsy_o) | dev_low);

    nvsc_host #(
        .SOFT_CMD_CYCLES (20),
        .RECALL_CYCLES   (40),
        .STORE_CYCLES    (60)
    ) u_nvsc_host (
        .i_clock            (i_clock),
        .i_rst              (i_rst),
        .i_ce               (i_ce),
        .i_req_valid        (i_req_valid),
        .i_req              (i_req),
        .o_req_ready        (o_req_ready),
        .o_rd_valid         (o_rd_valid),
        .o_rd_data          (o_rd_data),
        .o_nv_done          (o_nv_done),
        .o_pins             (o_pins),
        .i_dq               (dq_bus),
        .o_dq               (o_dq),
        .o_dq_oe            (o_dq_oe),
        .i_hw_store_busy_n  (bsy_wire),
        .o_hw_store_busy_n  (bsy_o),
        .o_hw_store_busy_oe (bsy_oe)
    );

    nvsc_dev_model u_nvsc_dev_model (
        .i_clock    (i_clock),
        .i_pins     (o_pins),
        .i_dq       (dq_bus),
        .i_dq_oe    (o_dq_oe),
        .i_busy_n   (bsy_wire),
        .o_dq       (dev_dq),
        .o_busy_low (dev_low),
        .o_viol     (viol)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // one request; cyc counts edges from the take to the answer
    task automatic do_op(input nvsc_pkg::nvsc_op_t op,
                         input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 3000) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        @(posedge i_clock);
        i_req_valid <= 1'b1;
        i_req       <= '{op: op, addr: a, wdata: d};
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        cyc = 2;
        while (op != WR && cyc < 3000 &&
               ((op == RD) ? o_rd_valid : o_nv_done) !== 1'b1) begin
            @(posedge i_clock);
            #1;
            cyc++;
        end
        rd = o_rd_data;
        if (n >= 3000 || cyc >= 3000) begin
            check(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : do_op

    task automatic t_reset();
        repeat (7) @(posedge i_clock);
        #1;
        check({o_pins.ce_n, o_pins.we_n, o_pins.oe_n, o_dq_oe, bsy_oe}, 5'h1c);
        @(posedge i_clock);
        i_rst <= 1'b0;
        $display("test reset done");
    endtask : t_reset

    // nothing written yet, so the store is skipped and busy frees fast
    task automatic t_hw_skip();
        do_op(ST, 15'h7fff, 8'h00);
        check(32'(cyc < 30), 32'h1);
        $display("test hw skip done");
    endtask : t_hw_skip

    task automatic t_rw();
        logic [14:0] a [3] = '{15'h0000, 15'h1234, 15'h7ffe};
        foreach (a[i]) do_op(WR, a[i], 8'(a[i]) ^ 8'h5a);
        foreach (a[i]) begin
            do_op(RD, a[i], 8'h00);
            check(rd, 8'(a[i]) ^ 8'h5a);
            check(cyc, nvsc_pkg::READ_CYCLE_CYC);
        end
        $display("test read write done");
    endtask : t_rw

    task automatic t_hw_store();
        do_op(WR, 15'h0200, 8'h77);
        do_op(ST, 15'h7fff, 8'h00);
        check(32'(cyc > 50), 32'h1);
        do_op(WR, 15'h0200, 8'h11);
        do_op(RC, 15'h0000, 8'h00);
        do_op(RD, 15'h0200, 8'h00);
        check(rd, 8'h77);
        $display("test hw store done");
    endtask : t_hw_store

    // sequence only counts if order, strobe width and we level are right
    task automatic t_soft();
        int v;
        do_op(WR, 15'h0300, 8'ha5);
        v = n_rdv;
        do_op(ST, 15'h0000, 8'h00);
        check(n_rdv, v);
        do_op(WR, 15'h0300, 8'h3c);
        do_op(RD, 15'h0300, 8'h00);
        check(rd, 8'h3c);
        do_op(RC, 15'h0000, 8'h00);
        check(n_rdv, v + 1);
        do_op(RD, 15'h0300, 8'h00);
        check(rd, 8'ha5);
        $display("test soft store recall done");
    endtask : t_soft

    initial begin
        t_reset();
        t_hw_skip();
        t_rw();
        t_hw_store();
        t_soft();
        check(viol, 8'h00);
        tally_and_finish();
    end
endmodule : nvsc_host_tb_top
